//--- hw/adder_tree.sv
// four-stage pipelined adder tree over sixteen complex products
`timescale 1ns/10ps
module adder_tree
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_valid,
   input wire logic i_last,
   input wire logic [bf_pkg::W_BEAM-1:0] i_beam,
   input wire logic signed [bf_pkg::W_PROD-1:0] i_re [bf_pkg::N_LANE],
   input wire logic signed [bf_pkg::W_PROD-1:0] i_im [bf_pkg::N_LANE],
   psum_if.src o_sum
);
   import bf_pkg::*;
   // level s holds W_PROD+s significant bits, sign-extended into W_TREE
   logic signed [W_TREE-1:0] t_re [TREE_STAGES+1][N_LANE];
   logic signed [W_TREE-1:0] t_im [TREE_STAGES+1][N_LANE];
   logic [TREE_STAGES-1:0] vld;
   logic [TREE_STAGES-1:0] lst;
   logic [W_BEAM-1:0] bm [TREE_STAGES];

   ////////////////////////////////////////////////////////////////////////
   // operand widening and one registered adder layer per stage
   genvar s, i;
   generate
      for (i = 0; i < N_LANE; i++)
      begin : g_in
         assign t_re[0][i] = W_TREE'(i_re[i]);
         assign t_im[0][i] = W_TREE'(i_im[i]);
      end
      for (s = 1; s <= TREE_STAGES; s++)
      begin : g_stage
         for (i = 0; i < N_LANE; i++)
         begin : g_node
            if (i < (N_LANE >> s))
            begin : g_add
               always_ff @(posedge i_clk)
               begin
                  t_re[s][i] <= t_re[s-1][2*i] + t_re[s-1][2*i+1];
                  t_im[s][i] <= t_im[s-1][2*i] + t_im[s-1][2*i+1];
               end
            end
            else
            begin : g_unused
               assign t_re[s][i] = '0;
               assign t_im[s][i] = '0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // beam number and flags travel alongside the sums
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         vld <= '0;
         lst <= '0;
      end
      else
      begin
         vld <= {vld[TREE_STAGES-2:0], i_valid};
         lst <= {lst[TREE_STAGES-2:0], i_last};
      end
   end

   always_ff @(posedge i_clk)
   begin
      bm[0] <= i_beam;
      for (int k = 1; k < TREE_STAGES; k++)
         bm[k] <= bm[k-1];
   end

   // final truncation back to product width
   assign o_sum.valid = vld[TREE_STAGES-1];
   assign o_sum.last = lst[TREE_STAGES-1];
   assign o_sum.beam = bm[TREE_STAGES-1];
   assign o_sum.re = t_re[TREE_STAGES][0][W_PROD-1:0];
   assign o_sum.im = t_im[TREE_STAGES][0][W_PROD-1:0];
endmodule : adder_tree

//--- hw/beam_accumulator.sv
// double-buffered per-beam accumulator with read-and-clear port
`timescale 1ns/10ps
module beam_accumulator
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   psum_if.dst i_sum,
   input wire logic i_rd_en,
   input wire logic [bf_pkg::W_BEAM-1:0] i_rd_beam,
   output logic signed [bf_pkg::W_ACC-1:0] o_rd_re,
   output logic signed [bf_pkg::W_ACC-1:0] o_rd_im,
   output logic o_last,
   output logic o_last_half
);
   import bf_pkg::*;
   logic signed [W_ACC-1:0] mem_re [2][N_BEAM];
   logic signed [W_ACC-1:0] mem_im [2][N_BEAM];
   logic half;
   logic a_valid;
   logic a_last;
   logic a_half;
   logic [W_BEAM-1:0] a_beam;
   logic signed [W_ACC-1:0] a_sum_re;
   logic signed [W_ACC-1:0] a_sum_im;
   logic signed [W_ACC-1:0] a_cur_re;
   logic signed [W_ACC-1:0] a_cur_im;
   wire logic rd_half = ~half;

   ////////////////////////////////////////////////////////////////////////
   // read stage: fetch running sum, swap half after the vector's last sum
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         half <= HALF_RESET;
         a_valid <= 1'b0;
         a_last <= 1'b0;
         a_half <= HALF_RESET;
         a_beam <= '0;
         a_sum_re <= '0;
         a_sum_im <= '0;
         a_cur_re <= '0;
         a_cur_im <= '0;
      end
      else
      begin
         if (i_sum.valid && i_sum.last)
            half <= ~half;
         a_valid <= i_sum.valid;
         a_last <= i_sum.last;
         a_half <= half;
         a_beam <= i_sum.beam;
         a_sum_re <= W_ACC'(i_sum.re);
         a_sum_im <= W_ACC'(i_sum.im);
         a_cur_re <= mem_re[half][i_sum.beam];
         a_cur_im <= mem_im[half][i_sum.beam];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write-back of the sum, and read-and-clear of the idle half
   // consecutive sums carry different beams, so no forwarding path exists
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         for (int h = 0; h < 2; h++)
            for (int b = 0; b < N_BEAM; b++)
            begin
               mem_re[h][b] <= '0;
               mem_im[h][b] <= '0;
            end
      end
      else
      begin
         if (a_valid)
         begin
            mem_re[a_half][a_beam] <= a_cur_re + a_sum_re;
            mem_im[a_half][a_beam] <= a_cur_im + a_sum_im;
         end
         if (i_rd_en)
         begin
            mem_re[rd_half][i_rd_beam] <= '0;
            mem_im[rd_half][i_rd_beam] <= '0;
         end
      end
   end

   // readout data and the completed-half notice
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_rd_re <= '0;
         o_rd_im <= '0;
         o_last <= 1'b0;
         o_last_half <= HALF_RESET;
      end
      else
      begin
         if (i_rd_en)
         begin
            o_rd_re <= mem_re[rd_half][i_rd_beam];
            o_rd_im <= mem_im[rd_half][i_rd_beam];
         end
         o_last <= a_valid && a_last;
         if (a_valid && a_last)
            o_last_half <= a_half;
      end
   end
endmodule : beam_accumulator

//--- hw/beamformer_core_datapath.sv
// beamformer core: channel queue, weight select, sample memories, multipliers
`timescale 1ns/10ps
module beamformer_core_datapath
#(
   parameter int SMP_DEPTH = bf_pkg::SMP_DEPTH_DEF,
   parameter int CHQ_DEPTH = bf_pkg::CHQ_DEPTH_DEF
)
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_chan_we,
   input wire logic [bf_pkg::W_CHAN-1:0] i_chan_num,
   output logic o_chan_full,
   input wire logic i_smp_we,
   input wire bf_pkg::cplx_smp_t [bf_pkg::N_LANE-1:0] i_smp,
   output logic o_work_req,
   input wire bf_pkg::cplx_wgt_t [bf_pkg::N_CHAN-1:0][bf_pkg::N_LANE-1:0] i_weight,
   input wire logic [bf_pkg::N_CHAN-1:0][bf_pkg::W_GRP-1:0] i_w_grp,
   input wire logic [bf_pkg::N_CHAN-1:0][bf_pkg::W_BEAM-1:0] i_w_beam,
   input wire logic i_rd_en,
   input wire logic [bf_pkg::W_BEAM-1:0] i_rd_beam,
   output logic signed [bf_pkg::W_ACC-1:0] o_rd_re,
   output logic signed [bf_pkg::W_ACC-1:0] o_rd_im,
   output logic o_last,
   output logic o_last_half,
   output logic o_busy
);
   import bf_pkg::*;

   localparam int AW = $clog2(SMP_DEPTH);
   localparam int QW = $clog2(CHQ_DEPTH);
   localparam logic [AW:0] VEC_WORDS = (AW+1)'(N_GRP);
   localparam logic [AW:0] DEPTH_WORDS = (AW+1)'(SMP_DEPTH);

   ////////////////////////////////////////////////////////////////////////
   // parameter checks
   generate
      if (SMP_DEPTH < 2 * N_GRP || (1 << AW) != SMP_DEPTH)
      begin : g_bad_depth
         $error("SMP_DEPTH must be a power of two of at least two vectors");
      end
      if (CHQ_DEPTH < 2 || (1 << QW) != CHQ_DEPTH)
      begin : g_bad_queue
         $error("CHQ_DEPTH must be a power of two of at least two");
      end
   endgenerate

   // ring address arithmetic over the sample memory
   function automatic logic [AW-1:0] ring_add(input logic [AW-1:0] a,
                                              input logic [AW-1:0] b);
      ring_add = AW'(a + b);
   endfunction : ring_add

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic [W_CHAN-1:0] chq [CHQ_DEPTH];
   logic [QW:0] chq_wr;
   logic [QW:0] chq_rd;
   // write and read pointers keep one wrap bit, so a full ring differs from an empty one
   logic [AW:0] wr_addr;
   logic [AW:0] rd_base;
   cplx_smp_t smem [N_LANE][SMP_DEPTH];
   ctl_state_t state;
   ctl_state_t next_state;
   logic [10:0] cyc;
   logic [W_CHAN-1:0] chan_cur;
   logic next_pop;
   cplx_wgt_t [N_LANE-1:0] w0;
   cplx_wgt_t [N_LANE-1:0] w1;
   logic [AW-1:0] raddr0;
   logic [W_BEAM-1:0] beam0;
   logic [W_BEAM-1:0] beam1;
   logic [W_BEAM-1:0] beam2;
   logic v0;
   logic v1;
   logic v2;
   logic last0;
   logic last1;
   logic last2;
   cplx_smp_t smp1 [N_LANE];
   logic signed [W_PROD-1:0] p_re [N_LANE];
   logic signed [W_PROD-1:0] p_im [N_LANE];

   ////////////////////////////////////////////////////////////////////////
   // occupancy and flow decoding
   wire logic chq_empty = (chq_wr == chq_rd);
   wire logic chq_full = (chq_wr[QW-1:0] == chq_rd[QW-1:0]) && (chq_wr[QW] != chq_rd[QW]);
   wire logic [AW:0] fill = wr_addr - rd_base;
   wire logic vec_ready = (fill >= VEC_WORDS);
   wire logic next_ready = (fill >= 2 * VEC_WORDS);
   wire logic at_last = (state == ST_RUN) && (cyc == LAST_CYCLE);
   wire logic chq_push = i_chan_we && !chq_full;
   wire logic [W_CHAN-1:0] chq_head = chq[chq_rd[QW-1:0]];
   wire cplx_wgt_t [N_LANE-1:0] w_sel = i_weight[chan_cur];
   wire logic [W_GRP-1:0] grp_sel = i_w_grp[chan_cur];
   wire logic [W_BEAM-1:0] beam_sel = i_w_beam[chan_cur];

   // status toward the scheduler
   assign o_chan_full = chq_full;
   assign o_work_req = (DEPTH_WORDS - fill) >= VEC_WORDS;
   assign o_busy = (state == ST_RUN);

   ////////////////////////////////////////////////////////////////////////
   // channel number queue written by the scheduler
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         chq_wr <= '0;
         chq_rd <= '0;
      end
      else
      begin
         if (chq_push)
            chq_wr <= chq_wr + 1'b1;
         if (next_pop)
            chq_rd <= chq_rd + 1'b1;
      end
   end

   // queue entries need no reset; only pushed entries are ever read
   always_ff @(posedge i_clk)
   begin
      if (chq_push)
         chq[chq_wr[QW-1:0]] <= i_chan_num;
   end

   ////////////////////////////////////////////////////////////////////////
   // shared sample write counter, endlessly wrapping
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         wr_addr <= '0;
      else if (i_smp_we)
         wr_addr <= wr_addr + 1'b1;
   end

   // sixteen sample memories, one lane each, one common write address
   always_ff @(posedge i_clk)
   begin
      if (i_smp_we)
      begin
         for (int l = 0; l < N_LANE; l++)
            smem[l][wr_addr[AW-1:0]] <= i_smp[l];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control: start when a channel number and a full vector are present
   always_comb
   begin
      next_state = state;
      next_pop = 1'b0;
      unique case (state)
         ST_IDLE:
         begin
            if (!chq_empty && vec_ready)
            begin
               next_state = ST_RUN;
               next_pop = 1'b1;
            end
         end
         ST_RUN:
         begin
            if (at_last)
            begin
               if (!chq_empty && next_ready)
                  next_pop = 1'b1;
               else
                  next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state <= ST_IDLE;
         cyc <= '0;
         chan_cur <= '0;
         rd_base <= '0;
      end
      else
      begin
         state <= next_state;
         if (next_pop)
            chan_cur <= chq_head;
         if (next_pop || state == ST_IDLE)
            cyc <= '0;
         else
            cyc <= cyc + 1'b1;
         if (at_last)
            rd_base <= rd_base + VEC_WORDS;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stage 0: weight and index select, read address from stream index
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         v0 <= 1'b0;
         last0 <= 1'b0;
      end
      else
      begin
         v0 <= (state == ST_RUN);
         last0 <= at_last;
      end
   end

   // data registers need no reset; the valid bits qualify them
   always_ff @(posedge i_clk)
   begin
      w0 <= w_sel;
      beam0 <= beam_sel;
      raddr0 <= ring_add(rd_base[AW-1:0], AW'(grp_sel));
   end

   ////////////////////////////////////////////////////////////////////////
   // stage 1: common-address sample read
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         v1 <= 1'b0;
         last1 <= 1'b0;
      end
      else
      begin
         v1 <= v0;
         last1 <= last0;
      end
   end

   // weights and beam number move along with the sample read
   always_ff @(posedge i_clk)
   begin
      w1 <= w0;
      beam1 <= beam0;
      for (int l = 0; l < N_LANE; l++)
         smp1[l] <= smem[l][raddr0];
   end

   ////////////////////////////////////////////////////////////////////////
   // stage 2: sixteen complex multipliers
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         v2 <= 1'b0;
         last2 <= 1'b0;
      end
      else
      begin
         v2 <= v1;
         last2 <= last1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      beam2 <= beam1;
      for (int l = 0; l < N_LANE; l++)
      begin
         p_re[l] <= W_PROD'(smp1[l].re * w1[l].re - smp1[l].im * w1[l].im);
         p_im[l] <= W_PROD'(smp1[l].re * w1[l].im + smp1[l].im * w1[l].re);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // adder tree and double-buffered accumulator
   psum_if sum_link ();

   adder_tree u_tree
   (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_valid(v2),
      .i_last(last2),
      .i_beam(beam2),
      .i_re(p_re),
      .i_im(p_im),
      .o_sum(sum_link.src)
   );

   beam_accumulator u_acc
   (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_sum(sum_link.dst),
      .i_rd_en(i_rd_en),
      .i_rd_beam(i_rd_beam),
      .o_rd_re(o_rd_re),
      .o_rd_im(o_rd_im),
      .o_last(o_last),
      .o_last_half(o_last_half)
   );
endmodule : beamformer_core_datapath

//--- hw/bf_pkg.sv
// constants and types shared by the beamformer core datapath
// Operation
// - queue channel numbers 0..7; current number selects one of eight weight streams
// - controller pops queue, counts cycles, flags vector end in cycle 2047
// - each clock take 16 weights, sample address, beam; read samples; multiply
// - all 16 sample memories share one read address every read cycle
// - scheduler writes 16 samples per clock; one write counter advances per enable
// - write address counter never stops, wraps to zero continuously
// - products travel to adder tree together with their beam number
// - four-stage pipelined binary adder tree, one 16-product sum per clock
// - tree operands start at 35 bits, grow one per stage, end truncated to 35
// - accumulator holds one complex 40-bit-per-part sum for each of 64 beams
// - beam number addresses read then write; new sum added and written back
// - beams innermost, so read and write addresses differ; no hazard logic
// - each beam sum completes after exactly 32 partial sums per vector
// - beam memory double buffered; halves swap in step with output stage
// - first sum after vector end goes to other half, already cleared by reader
// - vector-end flag also goes to output-stage controller
// - vector-end flag switches memory ports as it travels; no idle cycles
// - weights are complex, 19-bit two's complement real and imaginary parts
// - stream index picks samples so work may begin mid-sequence
// - raise work request while free sample storage fits another vector
// - samples complex, 16-bit real and 16-bit imaginary
package bf_pkg;
   localparam int N_CHAN = 8;
   localparam int N_LANE = 16;
   localparam int W_SMP = 16;
   localparam int W_WGT = 19;
   localparam int W_PROD = 35;
   localparam int TREE_STAGES = 4;
   localparam int W_TREE = W_PROD + TREE_STAGES;
   localparam int W_ACC = 40;
   localparam int N_BEAM = 64;
   localparam int N_GRP = 32;
   localparam int CYC_PER_VEC = 2048;
   localparam logic [10:0] LAST_CYCLE = 11'h7ff;
   localparam int OUT_READ_MAX = 128;
   localparam int SMP_DEPTH_DEF = 512;
   localparam int CHQ_DEPTH_DEF = 4;
   localparam int W_CHAN = 3;
   localparam int W_GRP = 5;
   localparam int W_BEAM = 6;
   localparam logic HALF_RESET = 1'b0;

   typedef struct packed
   {
      logic signed [W_SMP-1:0] re;
      logic signed [W_SMP-1:0] im;
   } cplx_smp_t;

   typedef struct packed
   {
      logic signed [W_WGT-1:0] re;
      logic signed [W_WGT-1:0] im;
   } cplx_wgt_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01
   } ctl_state_t;
endpackage : bf_pkg

//--- hw/psum_if.sv
// partial-sum stream from adder tree to accumulator
`timescale 1ns/10ps
interface psum_if;
   import bf_pkg::*;
   logic valid;
   logic last;
   logic [W_BEAM-1:0] beam;
   logic signed [W_PROD-1:0] re;
   logic signed [W_PROD-1:0] im;
   modport src (output valid, output last, output beam, output re, output im);
   modport dst (input valid, input last, input beam, input re, input im);
endinterface : psum_if

//--- testbench/beamformer_core_datapath_tb.sv
// self-checking bench for the beamformer core datapath
`timescale 1ns/10ps
module beamformer_core_datapath_tb;
   import bf_pkg::*;
   localparam int TIMEOUT = 16000;
   localparam int CHANS [6] = '{2, 5, 7, 0, 1, 3};
   localparam int ROW_SUM = N_GRP * (N_GRP + 1) / 2;
   logic i_clk;
   logic i_rst_b;
   logic i_chan_we;
   logic [W_CHAN-1:0] i_chan_num;
   logic i_smp_we;
   cplx_smp_t [N_LANE-1:0] i_smp;
   logic i_rd_en;
   logic [W_BEAM-1:0] i_rd_beam;
   cplx_wgt_t [N_CHAN-1:0][N_LANE-1:0] weight;
   logic [N_CHAN-1:0][W_GRP-1:0] w_grp;
   logic [N_CHAN-1:0][W_BEAM-1:0] w_beam;
   logic o_chan_full;
   logic o_work_req;
   logic o_last;
   logic o_last_half;
   logic o_busy;
   logic signed [W_ACC-1:0] o_rd_re;
   logic signed [W_ACC-1:0] o_rd_im;
   int err_count;
   int num_checks;
   int cycles;

   ////////////////////////////////////////////////////////////////////////////////////////
   // design and weight streams
   beamformer_core_datapath #(.SMP_DEPTH(SMP_DEPTH_DEF), .CHQ_DEPTH(CHQ_DEPTH_DEF))
      beamformer_core_datapath_inst
   (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_chan_we(i_chan_we),
      .i_chan_num(i_chan_num),
      .o_chan_full(o_chan_full),
      .i_smp_we(i_smp_we),
      .i_smp(i_smp),
      .o_work_req(o_work_req),
      .i_weight(weight),
      .i_w_grp(w_grp),
      .i_w_beam(w_beam),
      .i_rd_en(i_rd_en),
      .i_rd_beam(i_rd_beam),
      .o_rd_re(o_rd_re),
      .o_rd_im(o_rd_im),
      .o_last(o_last),
      .o_last_half(o_last_half),
      .o_busy(o_busy)
   );

   weight_stream_model weight_stream_model_inst
   (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .o_weight(weight),
      .o_grp(w_grp),
      .o_beam(w_beam)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // clock, hang guard, comparison and verdict
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == TIMEOUT)
      begin
         err_count++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [W_ACC-1:0] seen, input logic [W_ACC-1:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      if (err_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic check_reset;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      @(negedge i_clk);
      check(o_chan_full, 1'b0);
      check(o_work_req, 1'b1);
      check(o_busy, 1'b0);
      check(o_last, 1'b0);
   endtask : check_reset

   // whole vectors until storage is full, row r holding (r + 1) - 2j; no channel queued yet
   task automatic fill_rows;
      for (int v = 0; v < SMP_DEPTH_DEF / N_GRP; v++)
      begin
         for (int r = 0; r < N_GRP; r++)
         begin
            @(posedge i_clk);
            i_smp_we <= 1'b1;
            for (int l = 0; l < N_LANE; l++)
               i_smp[l].re <= W_SMP'(r + 1);
         end
         @(posedge i_clk);
         i_smp_we <= 1'b0;
         @(negedge i_clk);
         check(o_work_req, v < 15);
         check(o_busy, 1'b0);
      end
   endtask : fill_rows

   // six back-to-back pushes; the last one meets a full queue and is dropped
   task automatic push_chans;
      foreach (CHANS[k])
      begin
         @(posedge i_clk);
         i_chan_we <= 1'b1;
         i_chan_num <= W_CHAN'(CHANS[k]);
      end
      @(posedge i_clk);
      i_chan_we <= 1'b0;
      @(negedge i_clk);
      check(o_chan_full, 1'b1);
      check(o_busy, 1'b1);
   endtask : push_chans

   task automatic wait_last(output logic got);
      got = 1'b0;
      for (int n = 0; n < 2100 && !got; n++)
      begin
         @(negedge i_clk);
         got = o_last;
      end
   endtask : wait_last

   // read every beam of the finished half, then reread one to see it cleared
   task automatic read_half(input int c);
      @(posedge i_clk);
      i_rd_en <= 1'b1;
      i_rd_beam <= 6'h00;
      for (int b = 0; b < N_BEAM; b++)
      begin
         @(posedge i_clk);
         if (b < N_BEAM - 1)
            i_rd_beam <= W_BEAM'(b + 1);
         else
            i_rd_en <= 1'b0;
         @(negedge i_clk);
         check(o_rd_re, W_ACC'(N_LANE * (ROW_SUM * (c + 1) + 2 * N_GRP * c)));
         check(o_rd_im, W_ACC'(N_LANE * (ROW_SUM * c - 2 * N_GRP * (c + 1))));
      end
      @(posedge i_clk);
      i_rd_en <= 1'b1;
      i_rd_beam <= 6'h2a;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      @(negedge i_clk);
      check(o_rd_re, 40'h0);
   endtask : read_half

   // five queued vectors run seamlessly with alternating halves, then the core idles
   task automatic run_vectors;
      logic got;
      time last_at;
      last_at = 0;
      for (int k = 0; k < 5; k++)
      begin
         wait_last(got);
         check(got, 1'b1);
         check(o_last_half, k[0]);
         if (k > 0)
            check(W_ACC'(($time - last_at) / 40), W_ACC'(CYC_PER_VEC));
         last_at = $time;
         read_half(CHANS[k]);
      end
      wait_last(got);
      check(got, 1'b0);
      check(o_busy, 1'b0);
   endtask : run_vectors

   ////////////////////////////////////////////////////////////////////////////////////////
   // main sequence; every lane carries an imaginary part of -2
   initial
   begin
      err_count = 0;
      num_checks = 0;
      cycles = 0;
      i_rst_b = 1'b0;
      i_chan_we = 1'b0;
      i_chan_num = 3'h0;
      i_smp_we = 1'b0;
      i_rd_en = 1'b0;
      i_rd_beam = 6'h00;
      for (int l = 0; l < N_LANE; l++)
      begin
         i_smp[l].re = 16'h0003;
         i_smp[l].im = 16'hfffe;
      end
      check_reset();
      fill_rows();
      push_chans();
      run_vectors();
      tally_and_finish();
   end
endmodule : beamformer_core_datapath_tb

//--- testbench/bf_core_checker.sv
// concurrent checks on the beamformer core ports
`timescale 1ns/10ps
module bf_core_checker
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_chan_we,
   input wire logic o_chan_full,
   input wire logic i_smp_we,
   input wire logic o_work_req,
   input wire logic i_rd_en,
   input wire logic signed [bf_pkg::W_ACC-1:0] o_rd_re,
   input wire logic signed [bf_pkg::W_ACC-1:0] o_rd_im,
   input wire logic o_last,
   input wire logic o_last_half,
   input wire logic o_busy
);
   import bf_pkg::*;
   logic [10:0] busy_cnt;
   logic [10:0] next_busy_cnt;
   logic seen_last;
   logic prev_half;

   default clocking
      @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   ////////////////////////////////////////////////////////////////////////////////////////
   // busy cycles counted modulo one vector, last completed half remembered
   assign next_busy_cnt = o_busy ? busy_cnt + 11'h001 : 11'h000;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         busy_cnt <= 11'h000;
         seen_last <= 1'b0;
         prev_half <= 1'b0;
      end
      else
      begin
         busy_cnt <= next_busy_cnt;
         seen_last <= seen_last | o_last;
         if (o_last)
            prev_half <= o_last_half;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // port relations
   a_busy_whole_vec: assert property ($fell(o_busy) |-> busy_cnt == 11'h000)
      else $error("busy did not span whole vectors");
   a_last_after_end: assert property ($fell(o_busy) |-> ##[0:12] o_last)
      else $error("vector end not flagged to the reader");
   a_last_one_pulse: assert property (o_last |=> !o_last)
      else $error("vector end flag longer than one cycle");
   a_half_alternates: assert property (o_last && seen_last |-> o_last_half != prev_half)
      else $error("completed half did not alternate");
   a_first_half_zero: assert property (o_last && !seen_last |-> o_last_half == HALF_RESET)
      else $error("first completed half is not half zero");
   a_half_holds: assert property (!o_last |-> $stable(o_last_half))
      else $error("completed half changed without vector end");
   a_full_needs_push: assert property ($rose(o_chan_full) |-> $past(i_chan_we))
      else $error("queue full without a push");
   a_req_drop_write: assert property ($fell(o_work_req) |-> $past(i_smp_we))
      else $error("work request dropped without a sample write");
   a_rd_data_holds: assert property (!$past(i_rd_en) |-> $stable(o_rd_re) && $stable(o_rd_im))
      else $error("read data changed without a read");
endmodule : bf_core_checker

bind beamformer_core_datapath bf_core_checker bf_core_checker_inst
(
   .i_clk(i_clk),
   .i_rst_b(i_rst_b),
   .i_chan_we(i_chan_we),
   .o_chan_full(o_chan_full),
   .i_smp_we(i_smp_we),
   .o_work_req(o_work_req),
   .i_rd_en(i_rd_en),
   .o_rd_re(o_rd_re),
   .o_rd_im(o_rd_im),
   .o_last(o_last),
   .o_last_half(o_last_half),
   .o_busy(o_busy)
);

//--- testbench/weight_stream_model.sv
// weight stream model: eight banks sweeping beam fastest, then antenna group
`timescale 1ns/10ps
module weight_stream_model
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   output bf_pkg::cplx_wgt_t [bf_pkg::N_CHAN-1:0][bf_pkg::N_LANE-1:0] o_weight,
   output logic [bf_pkg::N_CHAN-1:0][bf_pkg::W_GRP-1:0] o_grp,
   output logic [bf_pkg::N_CHAN-1:0][bf_pkg::W_BEAM-1:0] o_beam
);
   import bf_pkg::*;
   logic [10:0] idx;

   // index walks all 2048 words; starts mid-sequence so the core must join anywhere
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         idx <= 11'h123;
      else
         idx <= idx + 11'h001;
   end

   // bank c shows sixteen weights (c+1) + j*c with its index, beam innermost
   always_comb
   begin
      for (int c = 0; c < N_CHAN; c++)
      begin
         o_grp[c] = idx[10:6];
         o_beam[c] = idx[5:0];
         for (int l = 0; l < N_LANE; l++)
         begin
            o_weight[c][l].re = W_WGT'(c + 1);
            o_weight[c][l].im = W_WGT'(c);
         end
      end
   end
endmodule : weight_stream_model
